/* sfpe_assertions.sv */
module sfpe_assertions
    import sfpe_pkg::*;
#(
    parameter int unsigned PP_CYC = 1,
    parameter int unsigned SE_CYC = 1,
    parameter int unsigned BE32_CYC = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic four_wire_command_mode,
    input wire logic target_protected,
    input wire logic rd_param_wr,
    input wire logic [1:0] rd_param_len,
    input wire logic rd_load,
    input wire logic rd_step,
    input wire logic mem_wr_valid,
    input wire logic busy_r,
    input wire logic write_enable_latch_r,
    input wire logic wrap_disable_bit_r,
    input wire logic [1:0] wrap_length_field_r,
    input wire logic erase_req_r,
    input wire logic [23:0] erase_base_r,
    input wire logic erase_block_r,
    input wire logic [23:0] rd_addr_r
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [31:0] bcnt_r;
    logic [31:0] bmin_r;
    logic [7:0] wmask;
    logic [23:0] wnxt;
    assign wmask = (8'h08 << wrap_length_field_r) - 8'h01;
    assign wnxt = (rd_addr_r & ~{16'h0, wmask})
        | ((rd_addr_r + 24'h1) & {16'h0, wmask});
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bcnt_r <= 32'h0;
        end else begin
            bcnt_r <= busy_r ? bcnt_r + 32'h1 : 32'h0;
        end
    end
    // The job that raised busy fixes how long busy must last at least.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bmin_r <= 32'h0;
        end else if (busy_r && bcnt_r == 32'h0) begin
            bmin_r <= !erase_req_r ? PP_CYC :
                erase_block_r ? BE32_CYC : SE_CYC;
        end
    end
    AST_RESET_STATE: assert property (
        $fell(rst) |-> wrap_disable_bit_r && !busy_r && !write_enable_latch_r)
        else $error("state after reset is wrong");
    AST_BUSY_NEEDS_LATCH: assert property (
        $rose(busy_r) |-> $past(write_enable_latch_r) && spi_cs_n)
        else $error("busy rose without latch or with select low");
    AST_BUSY_UNPROTECTED: assert property (
        $rose(busy_r) |-> !$past(target_protected))
        else $error("job started on a protected target");
    AST_END_CLEARS_LATCH: assert property (
        $fell(busy_r) |-> !write_enable_latch_r)
        else $error("latch still set after the cycle");
    AST_BUSY_LENGTH: assert property (
        $fell(busy_r) |-> bcnt_r >= bmin_r)
        else $error("self-timed cycle ended early");
    AST_ERASE_ALIGN: assert property (
        erase_req_r |-> busy_r && (erase_base_r
            & (erase_block_r ? BLOCK32_MASK : SECTOR_MASK)) == 24'h0)
        else $error("erase base not aligned or not busy");
    AST_ERASE_PULSE: assert property (
        erase_req_r |=> !erase_req_r)
        else $error("erase request longer than one cycle");
    AST_WRAP_CAPTURE: assert property (
        $changed(wrap_disable_bit_r) |-> !spi_cs_n && !four_wire_command_mode)
        else $error("wrap disable changed outside a frame");
    AST_PARAM_LEN: assert property (
        rd_param_wr && four_wire_command_mode
            |=> wrap_length_field_r == $past(rd_param_len))
        else $error("read parameter length not taken");
    AST_RD_WRAP: assert property (
        rd_step && !rd_load && !four_wire_command_mode && !wrap_disable_bit_r
            |=> rd_addr_r == $past(wnxt))
        else $error("wrapped read address wrong");
    AST_RD_LINEAR: assert property (
        rd_step && !rd_load && !four_wire_command_mode && wrap_disable_bit_r
            |=> rd_addr_r == $past(rd_addr_r) + 24'h1)
        else $error("linear read address wrong");
    AST_WR_IN_CYCLE: assert property (
        mem_wr_valid |-> busy_r)
        else $error("array write outside the program cycle");
    cover property ($rose(busy_r) && erase_req_r && erase_block_r);
    cover property ($fell(busy_r) && bmin_r == PP_CYC);
    cover property (rd_step && !wrap_disable_bit_r);
endmodule : sfpe_assertions

/* sfpe_host.sv */
module sfpe_host (
    output logic cs_n,
    output logic sck,
    output logic [3:0] io
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] q[$];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io = 4'h0;
    end
    // bytes MSB first under one low select, four bits a clock from byte qf on, the last byte short by cut clocks.
    task automatic frame(input int qf, input int cut);
        int nb;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < q.size(); i++) begin
            nb = (i >= qf) ? 2 : 8;
            for (int k = 0; k < nb; k++) begin
                if (i == q.size() - 1 && k == nb - cut) break;
                io = (nb == 2) ? q[i][7-4*k -: 4] : {~io[3:1], q[i][7-k]};
                #80 sck = 1'b1;
                #80 sck = 1'b0;
            end
        end
        #40 cs_n = 1'b1;
        // Released lines flip so that stale data never looks valid.
        io = ~io;
        q.delete();
        #200;
    endtask : frame
endmodule : sfpe_host

/* sfpe_pkg.sv */
package sfpe_pkg;
    localparam logic [7:0] OP_WRAP = 8'h77;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam int WRAP_DIS_BIT = 4;
    localparam int WRAP_LEN_LSB = 5;
    localparam logic WRAP_DIS_RST = 1'b1;
    localparam logic [1:0] WRAP_LEN_RST = 2'h0;
    localparam int ADDR_W = 24;
    localparam logic [11:0] CNT_ADDR_END = 12'h004;
    localparam logic [11:0] CNT_WRAP_BYTE = 12'h004;
    localparam logic [11:0] CNT_FIRST_DATA = 12'h005;
    localparam logic [23:0] SECTOR_MASK = 24'h000fff;
    localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
    localparam int PIN_CS = 5;
    localparam int PIN_SCK = 4;
    localparam logic [5:0] PIN_RST = 6'h20;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_MHZ = 200;
    localparam int PP_TIME_US = 400;
    localparam int SE_TIME_US = 45000;
    localparam int BE32_TIME_US = 120000;
    localparam int PP_CYCLES = PP_TIME_US * CLK_MHZ;
    localparam int SE_CYCLES = SE_TIME_US * CLK_MHZ;
    localparam int BE32_CYCLES = BE32_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } sfpe_wr_t;

    typedef enum logic [1:0] {CYC_IDLE, CYC_PROG, CYC_ERASE} sfpe_cyc_t;
endpackage : sfpe_pkg

/* sfpe_top.sv */
module sfpe_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    if (D < 2 || (1 << PW) != D) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2.");
    end

    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != CW'(D));
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_r];

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (clk_en && push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            out_valid <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + PW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + PW'(1);
            end
            cnt_r <= cnt_nxt;
            out_valid <= (cnt_nxt != '0);
        end
    end
endmodule : sfpe_fifo

module sfpe_top
    import sfpe_pkg::*;
#(
    parameter int unsigned PP_CYC = PP_CYCLES,
    parameter int unsigned SE_CYC = SE_CYCLES,
    parameter int unsigned BE32_CYC = BE32_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic [3:0] spi_io,
    input wire logic quad_io_enable,
    input wire logic four_wire_command_mode,
    input wire logic target_protected,
    input wire logic rd_param_wr,
    input wire logic [1:0] rd_param_len,
    input wire logic rd_load,
    input wire logic [23:0] rd_load_addr,
    input wire logic rd_step,
    input wire logic rd_burst_wrap,
    input wire logic mem_wr_ready,
    output logic mem_wr_valid,
    output sfpe_wr_t mem_wr,
    output logic busy_r,
    output logic write_enable_latch_r,
    output logic wrap_disable_bit_r,
    output logic [1:0] wrap_length_field_r,
    output logic [23:0] target_addr_r,
    output logic erase_req_r,
    output logic [23:0] erase_base_r,
    output logic erase_block_r,
    output logic [23:0] rd_addr_r
);
    if (PP_CYC < 1 || SE_CYC < 1 || BE32_CYC < 1) begin : g_bad_time
        $error("Cycle durations must be at least one clock.");
    end

    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_s3_r;
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic [3:0] io;

    logic [7:0] op_r;
    logic [7:0] sh_r;
    logic [2:0] bit_cnt_r;
    logic [11:0] byte_cnt_r;
    logic [7:0] col_r;
    logic [7:0] page_buf [256];
    logic [255:0] mask_r;

    logic quad_now;
    logic [7:0] sh_nxt;
    logic [2:0] bit_nxt;
    logic byte_done;
    logic on_boundary;
    logic prog_ok;
    logic erase_ok;
    logic start_prog;
    logic start_erase;
    logic cyc_done;

    sfpe_cyc_t cyc_r;
    logic [31:0] timer_r;
    logic [7:0] scan_idx_r;
    logic scan_done_r;
    logic fifo_in_valid;
    logic fifo_in_ready;
    sfpe_wr_t fifo_in;

    logic wrap_on;
    logic [7:0] wrap_mask;

    // Pins cross from the host's clock domain through two flops each; a third flop delays them for edge detection.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_r <= PIN_RST;
            pin_s2_r <= PIN_RST;
            pin_s3_r <= PIN_RST;
        end else if (clk_en) begin
            pin_s1_r <= {spi_cs_n, spi_sck, spi_io};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    assign cs_low = ~pin_s2_r[PIN_CS];
    assign cs_fall = ~pin_s2_r[PIN_CS] & pin_s3_r[PIN_CS];
    assign cs_rise = pin_s2_r[PIN_CS] & ~pin_s3_r[PIN_CS];
    assign sck_rise = pin_s2_r[PIN_SCK] & ~pin_s3_r[PIN_SCK];
    assign io = pin_s2_r[3:0];

    assign quad_now = four_wire_command_mode |
        ((op_r == OP_QPP) && (byte_cnt_r != '0));

    always_comb begin
        if (quad_now) begin
            sh_nxt = {sh_r[3:0], io};
            bit_nxt = bit_cnt_r + 3'h4;
        end else begin
            sh_nxt = {sh_r[6:0], io[0]};
            bit_nxt = bit_cnt_r + 3'h1;
        end
    end

    assign byte_done = cs_low & sck_rise & (bit_nxt == 3'h0);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_r <= '0;
            bit_cnt_r <= '0;
            byte_cnt_r <= '0;
            op_r <= '0;
            target_addr_r <= '0;
            col_r <= '0;
        end else if (clk_en) begin
            if (cs_fall) begin
                bit_cnt_r <= '0;
                byte_cnt_r <= '0;
            end else if (cs_low && sck_rise) begin
                sh_r <= sh_nxt;
                bit_cnt_r <= bit_nxt;
                if (bit_nxt == 3'h0) begin
                    if (byte_cnt_r != 12'hfff) begin
                        byte_cnt_r <= byte_cnt_r + 12'h001;
                    end
                    if (byte_cnt_r == '0) begin
                        op_r <= sh_nxt;
                    // A frame sent while busy must not move the scanned page.
                    end else if (byte_cnt_r < CNT_ADDR_END && !busy_r) begin
                        target_addr_r <= {target_addr_r[15:0], sh_nxt};
                        col_r <= sh_nxt;
                    end else begin
                        col_r <= col_r + 8'h01;
                    end
                end
            end
        end
    end

    // The page buffer holds data until the frame closes cleanly.
    always_ff @(posedge clock) begin
        if (clk_en && byte_done && !busy_r && byte_cnt_r >= CNT_ADDR_END &&
            (op_r == OP_PP || op_r == OP_QPP)) begin
            page_buf[col_r] <= sh_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_r <= '0;
        end else if (clk_en) begin
            if (cs_fall && !busy_r) begin
                mask_r <= '0;
            end else if (byte_done && !busy_r &&
                         byte_cnt_r >= CNT_ADDR_END &&
                         (op_r == OP_PP || op_r == OP_QPP)) begin
                mask_r[col_r] <= 1'b1;
            end
        end
    end

    assign on_boundary = cs_rise && (bit_cnt_r == 3'h0) && !busy_r;
    assign prog_ok = (byte_cnt_r >= CNT_FIRST_DATA) &&
        (op_r == OP_PP || (op_r == OP_QPP && quad_io_enable &&
                           !four_wire_command_mode));
    assign erase_ok = (byte_cnt_r == CNT_ADDR_END) &&
        (op_r == OP_SE || op_r == OP_BE32);
    assign start_prog = on_boundary && prog_ok &&
        write_enable_latch_r && !target_protected;
    assign start_erase = on_boundary && erase_ok &&
        write_enable_latch_r && !target_protected;

    assign cyc_done = (cyc_r != CYC_IDLE) && (timer_r == '0) &&
        (cyc_r == CYC_ERASE || (scan_done_r && !mem_wr_valid));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cyc_r <= CYC_IDLE;
            timer_r <= '0;
            busy_r <= 1'b0;
            erase_req_r <= 1'b0;
            erase_base_r <= '0;
            erase_block_r <= 1'b0;
        end else if (clk_en) begin
            erase_req_r <= 1'b0;
            case (cyc_r)
                CYC_IDLE: begin
                    if (start_prog) begin
                        cyc_r <= CYC_PROG;
                        timer_r <= PP_CYC;
                        busy_r <= 1'b1;
                    end else if (start_erase) begin
                        cyc_r <= CYC_ERASE;
                        busy_r <= 1'b1;
                        erase_req_r <= 1'b1;
                        erase_block_r <= (op_r == OP_BE32);
                        if (op_r == OP_BE32) begin
                            timer_r <= BE32_CYC;
                            erase_base_r <= target_addr_r & ~BLOCK32_MASK;
                        end else begin
                            timer_r <= SE_CYC;
                            erase_base_r <= target_addr_r & ~SECTOR_MASK;
                        end
                    end
                end
                CYC_PROG, CYC_ERASE: begin
                    if (timer_r != '0) begin
                        timer_r <= timer_r - 32'h1;
                    end
                    if (cyc_done) begin
                        cyc_r <= CYC_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                default: begin
                    cyc_r <= CYC_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // The scan stalls on a full FIFO, so a slow array throttles it.
    assign fifo_in_valid = (cyc_r == CYC_PROG) && !scan_done_r &&
        mask_r[scan_idx_r];
    assign fifo_in.addr = {target_addr_r[23:8], scan_idx_r};
    assign fifo_in.data = page_buf[scan_idx_r];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scan_idx_r <= '0;
            scan_done_r <= 1'b0;
        end else if (clk_en) begin
            if (start_prog) begin
                scan_idx_r <= '0;
                scan_done_r <= 1'b0;
            end else if (cyc_r == CYC_PROG && !scan_done_r &&
                         (!mask_r[scan_idx_r] || fifo_in_ready)) begin
                scan_idx_r <= scan_idx_r + 8'h01;
                if (scan_idx_r == 8'hff) begin
                    scan_done_r <= 1'b1;
                end
            end
        end
    end

    sfpe_fifo #(
        .W($bits(sfpe_wr_t)),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in),
        .in_ready(fifo_in_ready),
        .out_valid(mem_wr_valid),
        .out_data(mem_wr),
        .out_ready(mem_wr_ready)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            write_enable_latch_r <= 1'b0;
        end else if (clk_en) begin
            if (cyc_done) begin
                write_enable_latch_r <= 1'b0;
            end else if (on_boundary && byte_cnt_r == 12'h001) begin
                if (op_r == OP_WREN) begin
                    write_enable_latch_r <= 1'b1;
                end else if (op_r == OP_WRDI) begin
                    write_enable_latch_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrap_disable_bit_r <= WRAP_DIS_RST;
            wrap_length_field_r <= WRAP_LEN_RST;
        end else if (clk_en) begin
            if (byte_done && !busy_r && !four_wire_command_mode &&
                op_r == OP_WRAP && byte_cnt_r == CNT_WRAP_BYTE) begin
                wrap_disable_bit_r <= sh_nxt[WRAP_DIS_BIT];
                wrap_length_field_r <= sh_nxt[WRAP_LEN_LSB +: 2];
            end else if (rd_param_wr && four_wire_command_mode) begin
                wrap_length_field_r <= rd_param_len;
            end
        end
    end

    assign wrap_on = four_wire_command_mode ? rd_burst_wrap :
        !wrap_disable_bit_r;
    assign wrap_mask = (8'h08 << wrap_length_field_r) - 8'h01;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_addr_r <= '0;
        end else if (clk_en) begin
            if (rd_load) begin
                rd_addr_r <= rd_load_addr;
            end else if (rd_step) begin
                if (wrap_on) begin
                    rd_addr_r[7:0] <= (rd_addr_r[7:0] & ~wrap_mask) |
                        ((rd_addr_r[7:0] + 8'h01) & wrap_mask);
                end else begin
                    rd_addr_r <= rd_addr_r + 24'h000001;
                end
            end
        end
    end
endmodule : sfpe_top

/* sfpe_top_test.sv */
module sfpe_top_test import sfpe_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic spi_cs_n, spi_sck, quad_io_enable, four_wire_command_mode;
    logic target_protected, rd_param_wr, rd_load, rd_step, rd_burst_wrap;
    logic mem_wr_ready, mem_wr_valid, busy_r, write_enable_latch_r;
    logic wrap_disable_bit_r, erase_req_r, erase_block_r;
    logic [3:0] spi_io;
    logic [1:0] rd_param_len, wrap_length_field_r;
    logic [23:0] rd_load_addr, target_addr_r, erase_base_r, rd_addr_r, a;
    logic [7:0] w;
    logic [7:0] rop [5] = '{OP_PP, OP_PP, OP_SE, OP_QPP, OP_SE};
    logic [7:0] dq[$];
    sfpe_wr_t mem_wr;
    sfpe_wr_t wq[$];
    logic [31:0] seed = 32'h000173b9;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2.5 clock = ~clock;
    sfpe_host u_sfpe_host (.cs_n(spi_cs_n), .sck(spi_sck), .io(spi_io));
    sfpe_top #(.PP_CYC(300), .SE_CYC(400), .BE32_CYC(600)) u_sfpe_top (
        .clock, .rst, .clk_en, .spi_cs_n, .spi_sck, .spi_io, .quad_io_enable,
        .four_wire_command_mode, .target_protected, .rd_param_wr,
        .rd_param_len, .rd_load, .rd_load_addr, .rd_step, .rd_burst_wrap,
        .mem_wr_ready, .mem_wr_valid, .mem_wr, .busy_r, .write_enable_latch_r,
        .wrap_disable_bit_r, .wrap_length_field_r, .target_addr_r,
        .erase_req_r, .erase_base_r, .erase_block_r, .rd_addr_r);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [23:0] nxt(input logic [23:0] e,
                                        input logic wr, input logic [1:0] l);
        logic [23:0] m;
        m = {16'h0, (8'h08 << l) - 8'h01};
        return wr ? (e & ~m) | ((e + 24'h1) & m) : e + 24'h1;
    endfunction : nxt
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] ad,
                       input int nd, input int qf, input int cut,
                       input logic [7:0] d0);
        dq.delete();
        u_sfpe_host.q.push_back(op);
        for (int i = 0; i < na; i++) u_sfpe_host.q.push_back(ad[23-8*i -: 8]);
        for (int i = 0; i < nd; i++) begin
            dq.push_back(i == 0 ? d0 : 8'(rnd()));
            u_sfpe_host.q.push_back(dq[i]);
        end
        u_sfpe_host.frame(qf, cut);
    endtask : cmd
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy_r !== 1'b0; i++) @(posedge clock);
        #1;
    endtask : wait_idle
    task automatic rdchk(input logic wr, input logic [1:0] l);
        logic [23:0] e;
        e = 24'(rnd());
        rd_load_addr = e;
        rd_load = 1'b1;
        @(posedge clock) #1 rd_load = 1'b0;
        rd_step = 1'b1;
        for (int j = 0; j < 70; j++) begin
            @(posedge clock) #1 e = nxt(e, wr, l);
            check(rd_addr_r, e);
        end
        rd_step = 1'b0;
    endtask : rdchk
    task automatic prog_chk(input logic [23:0] pa);
        logic [7:0] img [256];
        bit hit [256];
        int n;
        n = 0;
        for (int i = 0; i < dq.size(); i++) begin
            img[8'(pa[7:0] + i)] = dq[i];
            hit[8'(pa[7:0] + i)] = 1'b1;
        end
        wait_idle();
        check(write_enable_latch_r, 0);
        for (int c = 0; c < 256; c++) begin
            if (hit[c]) begin
                check(wq[n], {pa[23:8], 8'(c), img[c]});
                n++;
            end
        end
        check(wq.size(), n);
    endtask : prog_chk
    always @(posedge clock) begin
        if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) wq.push_back(mem_wr);
        #1 mem_wr_ready = 1'(rnd());
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {quad_io_enable, four_wire_command_mode, target_protected} = 3'h0;
        {rd_param_wr, rd_load, rd_step, rd_burst_wrap, mem_wr_ready} = 5'h0;
        rd_param_len = 2'h0;
        rd_load_addr = 24'h0;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        check({busy_r, write_enable_latch_r, wrap_disable_bit_r}, 1);
        cmd(OP_PP, 3, 24'(rnd()), 1, 99, 0, 8'(rnd()));
        cmd(OP_SE, 3, 24'(rnd()), 0, 99, 0, 8'h0);
        check({busy_r, write_enable_latch_r}, 0);
        $display("test no latch done");
        for (int k = 0; k < 8; k++) begin
            w = 8'(rnd());
            w[6:4] = 3'(k);
            cmd(OP_WRAP, 3, 24'(rnd()), 1, 99, 0, w);
            check({wrap_length_field_r, wrap_disable_bit_r}, w[6:4]);
            rdchk(!w[4], w[6:5]);
        end
        four_wire_command_mode = 1'b1;
        rd_burst_wrap = 1'b1;
        rdchk(1'b1, 2'h3);
        for (int k = 0; k < 4; k++) begin
            rd_param_len = 2'(k);
            rd_param_wr = 1'b1;
            @(posedge clock) #1 rd_param_wr = 1'b0;
            check(wrap_length_field_r, k);
            rdchk(1'b1, 2'(k));
        end
        cmd(OP_WRAP, 3, 24'h0, 1, 0, 0, 8'h00);
        check({wrap_length_field_r, wrap_disable_bit_r}, 7);
        rd_burst_wrap = 1'b0;
        rdchk(1'b0, 2'h3);
        four_wire_command_mode = 1'b0;
        cmd(OP_WRAP, 3, 24'h0, 1, 99, 0, 8'h00);
        check({wrap_length_field_r, wrap_disable_bit_r}, 0);
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        check({busy_r, wrap_length_field_r, wrap_disable_bit_r}, 1);
        clk_en = 1'b0;
        a = rd_addr_r;
        rd_load_addr = ~a;
        rd_load = 1'b1;
        repeat (3) @(posedge clock);
        #1 check(rd_addr_r, a);
        clk_en = 1'b1;
        @(posedge clock) #1 rd_load = 1'b0;
        check(rd_addr_r, 24'(~a));
        $display("test wrap done");
        cmd(OP_WREN, 0, 24'h0, 0, 99, 0, 8'h0);
        for (int k = 0; k < 5; k++) begin
            target_protected = (k == 1 || k == 2);
            cmd(rop[k], 3, 24'(rnd()), (k == 2) ? 0 : (k == 0) ? 2 : 1,
                (k == 3) ? 1 : 99,
                (k == 0) ? 3 : 0, 8'(rnd()));
            check({busy_r, write_enable_latch_r}, 1);
        end
        target_protected = 1'b0;
        quad_io_enable = 1'b1;
        $display("test refusals done");
        for (int k = 0; k < 2; k++) begin
            cmd(OP_WREN, 0, 24'h0, 0, 99, 0, 8'h0);
            wq.delete();
            a = {16'(rnd()), (k == 1) ? 8'hfe : 8'hfd};
            cmd((k == 1) ? OP_PP : OP_QPP, 3, a, 6 - 2 * k, (k == 1) ? 99 : 1, 0,
                8'(rnd()));
            check(busy_r, 1);
            prog_chk(a);
        end
        $display("test program done");
        for (int k = 0; k < 2; k++) begin
            cmd(OP_WREN, 0, 24'h0, 0, 99, 0, 8'h0);
            a = 24'(rnd());
            cmd((k == 1) ? OP_BE32 : OP_SE, 3, a, 0, 99, 0, 8'h0);
            check(busy_r, 1);
            check(target_addr_r, a);
            check({erase_block_r, erase_base_r}, {k[0], a & ~((k == 1) ?
                BLOCK32_MASK : SECTOR_MASK)});
            wait_idle();
            check(write_enable_latch_r, 0);
        end
        $display("test erase done");
        end_sim();
    end
endmodule : sfpe_top_test
bind sfpe_top sfpe_assertions #(.PP_CYC(PP_CYC), .SE_CYC(SE_CYC),
    .BE32_CYC(BE32_CYC)) u_sfpe_assertions (.clock, .rst, .spi_cs_n,
    .four_wire_command_mode, .target_protected, .rd_param_wr, .rd_param_len,
    .rd_load, .rd_step, .mem_wr_valid, .busy_r, .write_enable_latch_r,
    .wrap_disable_bit_r, .wrap_length_field_r, .erase_req_r, .erase_base_r,
    .erase_block_r, .rd_addr_r);
